//--- src/sdw_pkg.sv
// Constants shared by the serial word loader and its register file.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
package sdw_pkg;

  // ==========================================================
  // Serial word layout.
  localparam int WORD_BITS = 16;
  localparam int CMD_BITS  = 4;
  localparam int CODE_BITS = 12;
  localparam int CNT_W     = 5;

  localparam logic [3:0] CMD_LOAD  = 4'h0;
  localparam logic [3:0] CMD_POWER = 4'hF;

  localparam logic [1:0] SEL_WAKE  = 2'h0;
  localparam logic [1:0] SEL_FLOAT = 2'h1;
  localparam logic [1:0] SEL_1K    = 2'h2;
  localparam logic [1:0] SEL_100K  = 2'h3;

  typedef enum logic [1:0] {
    PWR_ON,
    PWR_FLOAT,
    PWR_1K,
    PWR_100K
  } sdw_power_e;

  // ==========================================================
  // Reset values.
  localparam logic [11:0] CODE_RST = 12'h000;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;

  // ==========================================================
  // Timing.
  localparam int CLK_MHZ  = 125;
  localparam int WAKE_NS  = 8000;
  localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_W = 11;

  // ==========================================================
  // Register map, byte addresses on the AXI4-Lite bus.
  localparam int          ADDR_W   = 8;
  localparam logic [7:0]  CTRL_OFS = 8'h00;
  localparam logic [7:0]  STAT_OFS = 8'h04;
  localparam logic [7:0]  WORD_OFS = 8'h08;
  localparam logic [7:0]  CNT_OFS  = 8'h0C;

  localparam int CTRL_EN_BIT   = 0;
  localparam int STAT_MODE_LSB = 12;
  localparam int STAT_SET_BIT  = 16;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- src/sdw_word_loader.sv
// Control logic of a single-channel 12-bit serial-loaded converter.
// Assumes the serial master drives the select, clock and data pins and
// that the system side reaches the status and control over AXI4-Lite.
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

// What this block does, and what it expects of the host
// R1: Select low frames every serial transfer.
// R2: Data bit sampled on each falling clock.
// R3: Sixteenth bit moves word into converter latch.
// R4: Host may hold or release select after.
// R5: Select fall restarts collection at first bit.
// R6: Host keeps select high eighty nanoseconds between.
// R7: Select rising early discards partial word.
// R8: Serial clock idle level does not matter.
// R9: Command nibble first; zero loads code field.
// R10: All-ones command, low bits zero wakes.
// R11: Low bits pick float, 1k or 100k.
// R12: Power-down keeps stored code for wake.
// R13: Reset clears code, enters 100k power-down.
// R14: Host waits eight microseconds after wake.
// R15: Code is straight unsigned binary.
// R16: Other command values are ignored.
// R17: Extra clocks after sixteenth bit ignored.
module sdw_word_loader
  import sdw_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  input  wire logic                 sclk_i,
  input  wire logic                 cs_n_i,
  input  wire logic                 din_i,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr_i,
  input  wire logic                 s_axi_awvalid_i,
  output logic                      s_axi_awready_o,
  input  wire logic [31:0]          s_axi_wdata_i,
  input  wire logic [3:0]           s_axi_wstrb_i,
  input  wire logic                 s_axi_wvalid_i,
  output logic                      s_axi_wready_o,
  output logic [1:0]                s_axi_bresp_o,
  output logic                      s_axi_bvalid_o,
  input  wire logic                 s_axi_bready_i,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr_i,
  input  wire logic                 s_axi_arvalid_i,
  output logic                      s_axi_arready_o,
  output logic [31:0]               s_axi_rdata_o,
  output logic [1:0]                s_axi_rresp_o,
  output logic                      s_axi_rvalid_o,
  input  wire logic                 s_axi_rready_i,
  output logic [CODE_BITS-1:0]      dac_code_o,
  output logic                      buf_on_o,
  output logic                      term_1k_o,
  output logic                      term_100k_o,
  output logic                      settling_o
);

  // ==========================================================
  // Serial clock domain.

  logic [CNT_W-1:0]     bit_cnt_reg;
  logic [WORD_BITS-2:0] shift_reg;
  logic [WORD_BITS-1:0] word_hold_reg;
  logic                 word_tog_reg;
  wire                  last_bit;
  wire                  cnt_live;

  // The count is cleared by select itself, so a word can restart even
  // when the serial clock stands still while select is high.
  assign cnt_live = (bit_cnt_reg != CNT_W'(WORD_BITS)); // R17
  assign last_bit = (bit_cnt_reg == CNT_W'(WORD_BITS - 1)); // R3

  // Bit counter; only falling edges count, so either idle level works.
  // Select high holds it at zero, which also throws away a cut word.
  always_ff @(negedge sclk_i or posedge cs_n_i) begin // R8
    if (cs_n_i) begin
      bit_cnt_reg <= '0; // R1 R5 R7
    end else if (cnt_live) begin
      bit_cnt_reg <= bit_cnt_reg + CNT_W'(1); // R17
    end
  end

  // Shifter takes the data pin on every falling edge, MSB first.
  // It has no reset: the counter alone decides which bits count, so
  // stale contents never reach the held word.
  always_ff @(negedge sclk_i) begin
    shift_reg <= {shift_reg[WORD_BITS-3:0], din_i}; // R2 R9
  end

  // A full word is frozen and announced by a toggle. A partial word
  // never reaches here because select clears the counter first.
  always_ff @(negedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      word_hold_reg <= '0;
      word_tog_reg  <= 1'b0;
    end else if (last_bit) begin
      word_hold_reg <= {shift_reg, din_i}; // R3 R7
      word_tog_reg  <= ~word_tog_reg;
    end
  end

  // ==========================================================
  // Crossing into the system clock domain.

  logic tog_meta_reg;
  logic tog_sync_reg;
  logic tog_seen_reg;
  wire  word_arrived;

  // The held word stays stable for at least sixteen serial clocks, far
  // longer than the three system cycles the toggle takes to arrive.
  // The edge register only sees the second stage, never the first.
  assign word_arrived = tog_sync_reg ^ tog_seen_reg;

  // Two-stage toggle synchroniser plus an edge register.
  // Reset clears all three, matching the cleared toggle on the link side.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tog_meta_reg <= 1'b0;
      tog_sync_reg <= 1'b0;
      tog_seen_reg <= 1'b0;
    end else begin
      tog_meta_reg <= word_tog_reg;
      tog_sync_reg <= tog_meta_reg;
      tog_seen_reg <= tog_sync_reg;
    end
  end

  // ==========================================================
  // Command decode.
  // Everything from here on runs on the system clock and reads the
  // held word only while the arrival pulse says it is stable.

  logic [31:0]          ctrl_reg;
  logic [CODE_BITS-1:0] code_reg;
  sdw_power_e           mode_reg;
  logic [SETTLE_W-1:0]  settle_reg;
  logic [WORD_BITS-1:0] last_word_reg;
  logic [COUNT_W-1:0]   word_cnt_reg;

  wire [CMD_BITS-1:0]  cmd_nibble;
  wire [CODE_BITS-1:0] code_field;
  wire [1:0]           pd_sel;
  wire                 accept;
  wire                 is_load;
  wire                 is_power;
  wire                 is_wake;
  sdw_power_e          sel_mode;
  sdw_power_e          mode_next;
  wire [CODE_BITS-1:0] code_next;
  wire [SETTLE_W-1:0]  settle_next;

  assign cmd_nibble = word_hold_reg[WORD_BITS-1:CODE_BITS]; // R9
  assign code_field = word_hold_reg[CODE_BITS-1:0];
  assign pd_sel     = word_hold_reg[1:0];

  // Software may mute the serial port; words then pass unseen.
  // A muted word is neither decoded nor counted.
  assign accept   = word_arrived & ctrl_reg[CTRL_EN_BIT];
  assign is_load  = accept & (cmd_nibble == CMD_LOAD); // R9
  assign is_power = accept & (cmd_nibble == CMD_POWER); // R16
  assign is_wake  = is_power & (pd_sel == SEL_WAKE); // R10

  // Only the two low bits of a power word matter.
  assign sel_mode = (pd_sel == SEL_FLOAT) ? PWR_FLOAT : // R11
                    (pd_sel == SEL_1K)    ? PWR_1K    :
                    (pd_sel == SEL_100K)  ? PWR_100K  : PWR_ON;

  // Power words never touch the code, so wake restores it unchanged.
  // A load while powered down is stored and shows at the next wake.
  assign mode_next = is_power ? sel_mode : mode_reg; // R12 R16
  assign code_next = is_load ? code_field : code_reg; // R9 R12 R16

  // Wake-up starts a settling window reported to software; the
  // converter does not refuse loads during it.
  assign settle_next = is_wake ? SETTLE_W'(WAKE_CYC) :
                       (settle_reg != '0) ?
                       settle_reg - SETTLE_W'(1) : settle_reg; // R14

  // Converter state and the analog controls it drives.
  // The code output follows the stored code even while powered down,
  // so the level seen at wake-up is already in place.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      code_reg    <= CODE_RST; // R13
      mode_reg    <= PWR_100K; // R13
      dac_code_o  <= CODE_RST;
      buf_on_o    <= 1'b0;
      term_1k_o   <= 1'b0;
      term_100k_o <= 1'b1; // R13
    end else begin
      code_reg    <= code_next;
      mode_reg    <= mode_next;
      dac_code_o  <= code_next; // R15
      buf_on_o    <= (mode_next == PWR_ON); // R10
      term_1k_o   <= (mode_next == PWR_1K); // R11
      term_100k_o <= (mode_next == PWR_100K); // R11
    end
  end

  // Settling timer and word bookkeeping.
  // Every accepted word is counted and kept, also one with an unused
  // command, so software can see what the host really sent.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      settle_reg    <= '0;
      settling_o    <= 1'b0;
      last_word_reg <= '0;
      word_cnt_reg  <= '0;
    end else begin
      settle_reg <= settle_next;
      settling_o <= (settle_next != '0);
      if (accept) begin
        last_word_reg <= word_hold_reg;
        word_cnt_reg  <= word_cnt_reg + COUNT_W'(1);
      end
    end
  end

  // ==========================================================
  // AXI4-Lite write channel.

  logic [ADDR_W-1:0] aw_addr_reg;
  logic              aw_held_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              w_held_reg;

  wire aw_take;
  wire w_take;
  wire wr_fire;
  wire wr_hit;
  wire aw_held_next;
  wire w_held_next;

  // Address and data are taken in either order; the write happens once
  // both are held and no response is still waiting.
  // Holding a ready low while its half is held keeps a second address
  // or data word from overwriting the first before it is used.
  assign aw_take      = s_axi_awvalid_i & s_axi_awready_o;
  assign w_take       = s_axi_wvalid_i & s_axi_wready_o;
  assign wr_fire      = aw_held_reg & w_held_reg & ~s_axi_bvalid_o;
  assign wr_hit       = (aw_addr_reg == CTRL_OFS);
  assign aw_held_next = wr_fire ? 1'b0 : (aw_held_reg | aw_take);
  assign w_held_next  = wr_fire ? 1'b0 : (w_held_reg | w_take);

  // Write holding registers and handshake flags.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aw_held_reg     <= 1'b0;
      w_held_reg      <= 1'b0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
    end else begin
      aw_held_reg     <= aw_held_next;
      w_held_reg      <= w_held_next;
      s_axi_awready_o <= ~aw_held_next;
      s_axi_wready_o  <= ~w_held_next;
    end
  end

  // Payload capture.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
    end else begin
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
    end
  end

  // Only the control word is writable; the rest answer with an error.
  // A write with the low strobe clear is answered but changes nothing.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctrl_reg       <= CTRL_RST;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
    end else begin
      if (wr_fire && wr_hit && w_strb_reg[0]) begin
        ctrl_reg <= {31'h0000_0000, w_data_reg[CTRL_EN_BIT]};
      end
      if (wr_fire) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel.

  logic [31:0] rd_word;
  logic        rd_hit;
  wire         ar_take;

  assign ar_take = s_axi_arvalid_i & s_axi_arready_o;

  // Read address decode.
  // Unknown offsets read as zero and answer with an error response.
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (s_axi_araddr_i == CTRL_OFS) begin
      rd_word = ctrl_reg;
    end else if (s_axi_araddr_i == STAT_OFS) begin
      rd_word[CODE_BITS-1:0]          = code_reg;
      rd_word[STAT_MODE_LSB+1:STAT_MODE_LSB] = mode_reg;
      rd_word[STAT_SET_BIT]           = settling_o;
    end else if (s_axi_araddr_i == WORD_OFS) begin
      rd_word[WORD_BITS-1:0] = last_word_reg;
    end else if (s_axi_araddr_i == CNT_OFS) begin
      rd_word[COUNT_W-1:0] = word_cnt_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read response; the address port is closed while data waits.
  // Only one read is ever outstanding, so no reorder logic is needed.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= '0;
      s_axi_rresp_o   <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= rd_word;
      s_axi_rresp_o   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
    end
  end

endmodule

//--- tb/sdw_word_loader_asserts.sv
// Checker for the serial word loader, watching its ports only.
// Assumes a bind onto the loader top; clock_i domain, rst_i reset.
`timescale 1ns/1ps
module sdw_word_loader_chk (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        cs_n_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [11:0] dac_code_o,
  input wire logic        buf_on_o,
  input wire logic        term_1k_o,
  input wire logic        term_100k_o,
  input wire logic        settling_o
);
  // ====================
  // Run lengths; counters keep long spans out of repetitions.
  logic [10:0] hi_cnt;
  logic [3:0]  up_cnt;
  always_ff @(posedge clock_i) begin
    hi_cnt <= (rst_i || !settling_o) ? 11'h000 : hi_cnt + 11'h001;
    up_cnt <= (rst_i || !cs_n_i) ? 4'h0 : up_cnt + {3'h0, ~&up_cnt};
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence wr_both;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  // ====================
  // Output relations.
  one_mode_a: assert property (
    $onehot0({buf_on_o, term_1k_o, term_100k_o})) else $error("two modes");
  keep_code_a: assert property (
    $changed({buf_on_o, term_1k_o, term_100k_o}) |-> $stable(dac_code_o))
    else $error("code moved with mode");
  framed_out_a: assert property (
    $changed({dac_code_o, buf_on_o, term_1k_o, term_100k_o})
    |-> up_cnt < 4'h8) else $error("output moved without a frame");
  wake_len_a: assert property (
    $fell(settling_o) |-> hi_cnt >= 11'h3E8) else $error("short wake");
  wake_on_a: assert property (
    $rose(settling_o) |-> buf_on_o) else $error("wake without power");
  // ====================
  // Bus handshakes.
  wr_lat_a: assert property ( // AXI
    wr_both |=> !s_axi_awready_o ##1 s_axi_bvalid_o)
    else $error("write answer late");
  b_done_a: assert property ( // AXI
    s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write answer stuck");
  rd_lat_a: assert property ( // AXI
    rd_take |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read answer late");
  r_done_a: assert property ( // AXI
    s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o)
    else $error("read answer stuck");
endmodule
bind sdw_word_loader sdw_word_loader_chk sdw_word_loader_chk_inst (.*);

//--- tb/sdw_host_model.sv
// Host serial master model: drives select, serial clock and data.
// Assumes calls from the bench never overlap; 6 ns serial clock.
`timescale 1ns/1ps
module sdw_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  // ====================
  // Idle state: select high, clock parked.
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
  end
  // Fewer than 16 bits aborts a word; more tests the ignore path.
  task automatic send_word(input logic [15:0] w, input int nbits,
                           input logic idle_hi);
    sclk_o = idle_hi;
    #80;
    cs_n_o = 1'b0;
    #15;
    for (int i = 0; i < nbits; i++) begin
      din_o  = w[15 - (i % 16)];
      sclk_o = 1'b1;
      #3;
      sclk_o = 1'b0;
      #3;
    end
    #7;
    sclk_o = idle_hi;
    cs_n_o = 1'b1;
    din_o  = ~din_o;
  endtask
endmodule

//--- tb/sdw_word_loader_tb.sv
// Self-checking bench for the serial word loader.
// Assumes the host model owns the serial pins; the bench owns the bus.
`timescale 1ns/1ps
module sdw_word_loader_tb;
  import sdw_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i = 4'hF;
  logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
  logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic        s_axi_bready_i = 1'b0, s_axi_awready_o, s_axi_wready_o;
  logic        s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic        buf_on_o, term_1k_o, term_100k_o, settling_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [11:0] dac_code_o;
  logic        sclk_i, cs_n_i, din_i;
  int          n_fail = 0;
  int          total_checks = 0;
  // Free-running system clock, 8 ns.
  always #4 clock_i = ~clock_i;
  sdw_word_loader sdw_word_loader_inst (.*);
  sdw_host_model sdw_host_model_inst (.sclk_o(sclk_i), .cs_n_o(cs_n_i),
                                      .din_o(din_i));
  // ====================
  // Checking and closing.
  task automatic chk(input string nm, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // A wait that runs past its bound ends the run as a mismatch.
  task automatic tick(inout int n);
    @(posedge clock_i);
    n++;
    if (n > 50) begin
      chk("bus wait", 0, 1);
      tally_and_finish();
    end
  endtask
  // ====================
  // Bus cycles.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n = 0;
    logic done = 1'b0;
    @(posedge clock_i);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    while (!done) begin
      tick(n);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o) begin
        done = 1'b1;
        s_axi_bready_i <= 1'b0;
        chk("bresp", er, s_axi_bresp_o);
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    int n = 0;
    logic done = 1'b0;
    @(posedge clock_i);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    while (!done) begin
      tick(n);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o) begin
        done = 1'b1;
        s_axi_rready_i <= 1'b0;
        chk("rdata", ed, s_axi_rdata_o);
        chk("rresp", er, s_axi_rresp_o);
      end
    end
  endtask
  // Outputs settle within three cycles of the last bit; six are allowed.
  task automatic word(input logic [15:0] w, input int nb, input logic hi);
    sdw_host_model_inst.send_word(w, nb, hi);
    repeat (6) @(posedge clock_i);
  endtask
  task automatic outs(input logic [11:0] c, input logic [2:0] m);
    chk("code", c, dac_code_o);
    chk("mode", m, {buf_on_o, term_1k_o, term_100k_o});
  endtask
  task automatic reset_dut();
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    #1;
    outs(12'h000, 3'h1);
  endtask
  // ====================
  // Main sequence.
  initial begin
    reset_dut();
    rd(CTRL_OFS, 32'h0000_0001, RESP_OKAY);
    word(16'h0ABC, 16, 1'b0);
    outs(12'hABC, 3'h1);
    word(16'hF000, 16, 1'b1);
    outs(12'hABC, 3'h4);
    chk("settling", 1, settling_o);
    repeat (1010) @(posedge clock_i);
    chk("settling", 0, settling_o);
    for (int s = 1; s < 4; s++) begin
      word({12'hFFF, 2'h3, s[1:0]}, 16, 1'b0);
      outs(12'hABC, (s == 1) ? 3'h0 : (s == 2) ? 3'h2 : 3'h1);
      rd(STAT_OFS, {18'h0, s[1:0], 12'hABC}, RESP_OKAY);
    end
    word(16'hFFFC, 16, 1'b0);
    outs(12'hABC, 3'h4);
    repeat (1010) @(posedge clock_i);
    word(16'h0FFF, 16, 1'b1);
    outs(12'hFFF, 3'h4);
    rd(STAT_OFS, 32'h0000_0FFF, RESP_OKAY);
    word(16'h0123, 15, 1'b0);
    outs(12'hFFF, 3'h4);
    word(16'h0456, 20, 1'b0);
    outs(12'h456, 3'h4);
    rd(WORD_OFS, 32'h0000_0456, RESP_OKAY);
    word(16'h5777, 16, 1'b0);
    outs(12'h456, 3'h4);
    rd(CNT_OFS, 32'h0000_0009, RESP_OKAY);
    wr(STAT_OFS, 32'h0, RESP_SLVERR);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(CTRL_OFS, 32'h0, RESP_OKAY);
    word(16'h0001, 16, 1'b0);
    outs(12'h456, 3'h4);
    rd(CNT_OFS, 32'h0000_0009, RESP_OKAY);
    wr(CTRL_OFS, 32'h1, RESP_OKAY);
    s_axi_wstrb_i <= 4'h0;
    wr(CTRL_OFS, 32'h0, RESP_OKAY);
    s_axi_wstrb_i <= 4'hF;
    rd(CTRL_OFS, 32'h0000_0001, RESP_OKAY);
    reset_dut();
    tally_and_finish();
  end
endmodule
